// [adc_decimation_and_dc_block.sv]
/*
 * One channel of sinc3 decimation with fast-startup sinc1 path, settling
 * tracking, DC block stage and a classic Wishbone register slave.
 * Assumes clk_i is the master clock and mod_bit_i the modulator stream,
 * one new bit every second master clock; both pins are asynchronous.
 */

`include "adc_filter_regs.svh"

module adc_decimation_and_dc_block import adc_filter_pkg::*; #(
	parameter int unsigned SETTLE_OSR1024 = `SETTLE_OSR1024,
	parameter int unsigned SETTLE_OSR2048 = `SETTLE_OSR2048,
	parameter int unsigned SETTLE_OSR4096 = `SETTLE_OSR4096,
	parameter int unsigned SETTLE_OSR8192 = `SETTLE_OSR8192,
	parameter int unsigned SETTLE_OSR16384 = `SETTLE_OSR16384
) (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input logic mod_bit_i,
	input logic sync_i,
	output logic signed [23:0] data_o,
	output logic data_valid_o,
	output logic settled_o,
	output power_mode_t power_mode_o
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [14:0] osr_len(input logic [2:0] sel);
		osr_len = 15'h0080 << sel;
	endfunction

	function automatic logic [16:0] settle_target(input logic [2:0] sel);
		unique case (sel)
			3'h0: settle_target = 17'(`SETTLE_OSR128);
			3'h1: settle_target = 17'(`SETTLE_OSR256);
			3'h2: settle_target = 17'(`SETTLE_OSR512);
			3'h3: settle_target = 17'(SETTLE_OSR1024);
			3'h4: settle_target = 17'(SETTLE_OSR2048);
			3'h5: settle_target = 17'(SETTLE_OSR4096);
			3'h6: settle_target = 17'(SETTLE_OSR8192);
			3'h7: settle_target = 17'(SETTLE_OSR16384);
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] mod_sync;
	logic [1:0] resync_sync;
	logic resync_prev;
	logic resync_rise;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mod_sync <= 2'h0;
			resync_sync <= 2'h0;
			resync_prev <= 1'b0;
		end else begin
			mod_sync <= {mod_sync[0], mod_bit_i};
			resync_sync <= {resync_sync[0], sync_i};
			resync_prev <= resync_sync[1];
		end
	end

	assign resync_rise = resync_sync[1] && !resync_prev;

	// ------------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------------
	logic [2:0] decimation_ratio_sel;
	logic [3:0] hpf_coeff_sel;
	logic chan_enable;
	logic chan_hpf_disable;
	logic [1:0] chan_mux;
	logic [2:0] chan_gain;
	logic bus_req;
	logic bus_commit;
	logic restart;
	logic next_restart;
	path_t path;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the edge at which the master samples ack
	assign bus_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				unique case (wb_adr_i)
					`CLOCK_REG_ADDR: wb_dat_o <= 32'({power_mode_o, 5'h00,
						decimation_ratio_sel});
					`HPF_REG_ADDR: wb_dat_o <= 32'(hpf_coeff_sel);
					`CHAN_CFG_ADDR: wb_dat_o <= 32'({chan_gain, chan_mux,
						chan_hpf_disable, chan_enable});
					`STATUS_ADDR: wb_dat_o <= 32'({path != sinc3_path,
						settled_o});
					`DATA_ADDR: wb_dat_o <= 32'(data_o);
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			decimation_ratio_sel <= `OSR_SEL_RST;
			power_mode_o <= power_mode_t'(`PWR_RST);
			hpf_coeff_sel <= `HPF_SEL_RST;
			chan_enable <= `CHAN_EN_RST;
			chan_hpf_disable <= `CHAN_HPF_DIS_RST;
			chan_mux <= `CHAN_MUX_RST;
			chan_gain <= `CHAN_GAIN_RST;
		end else if (bus_commit) begin
			if (wb_adr_i == `CLOCK_REG_ADDR && wb_sel_i[0])
				decimation_ratio_sel <= wb_dat_i[`CLK_OSR_LSB +: 3];
			if (wb_adr_i == `CLOCK_REG_ADDR && wb_sel_i[1])
				power_mode_o <= power_mode_t'(wb_dat_i[`CLK_PWR_LSB +: 2]);
			if (wb_adr_i == `HPF_REG_ADDR && wb_sel_i[0])
				hpf_coeff_sel <= wb_dat_i[`HPF_SEL_LSB +: 4];
			if (wb_adr_i == `CHAN_CFG_ADDR && wb_sel_i[0]) begin
				chan_enable <= wb_dat_i[`CHAN_EN_BIT];
				chan_hpf_disable <= wb_dat_i[`CHAN_HPF_DIS_BIT];
				chan_mux <= wb_dat_i[`CHAN_MUX_LSB +: 2];
				chan_gain <= wb_dat_i[`CHAN_GAIN_LSB +: 3];
			end
		end
	end

	// Settling restarts; the phase offset is not an input here
	always_comb begin
		next_restart = resync_rise;
		if (bus_commit && wb_sel_i[0]) begin
			if (wb_adr_i == `CHAN_CFG_ADDR && (
				(wb_dat_i[`CHAN_EN_BIT] && !chan_enable) ||
				wb_dat_i[`CHAN_MUX_LSB +: 2] != chan_mux ||
				wb_dat_i[`CHAN_GAIN_LSB +: 3] != chan_gain))
				next_restart = 1'b1;
			if (wb_adr_i == `CLOCK_REG_ADDR &&
				wb_dat_i[`CLK_OSR_LSB +: 3] != decimation_ratio_sel)
				next_restart = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			restart <= 1'b0;
		else
			restart <= next_restart;
	end

	// ------------------------------------------------------------------
	// Sinc3 decimator with sinc1 fast-startup path
	// ------------------------------------------------------------------
	logic mod_tick;
	logic dec_tick;
	logic [13:0] dec_cnt;
	logic signed [43:0] int1, int2, int3;
	logic signed [43:0] dly1, dly2, dly3;
	logic signed [43:0] comb1, comb2, comb3;
	logic signed [43:0] bit_val;
	logic signed [15:0] fast_acc;
	logic signed [15:0] fast_sum;
	logic signed [47:0] sinc3_scaled;
	logic signed [47:0] sinc1_scaled;
	logic [4:0] sinc3_shift;
	logic filt_clear;
	hpf_if hpf();

	// The modulator delivers one bit every second master clock
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mod_tick <= 1'b0;
		else
			mod_tick <= !mod_tick;
	end

	assign filt_clear = restart || !chan_enable;
	assign dec_tick = mod_tick && !filt_clear &&
		dec_cnt == 14'(osr_len(decimation_ratio_sel) - 15'h0001);

	always_comb begin
		bit_val = mod_sync[1] ? 44'sh00000000001 : -44'sh00000000001;
		// Combs act on the integrator before this bit, one modulator
		// sample of delay with no effect on the response
		comb1 = int3 - dly1;
		comb2 = comb1 - dly2;
		comb3 = comb2 - dly3;
		fast_sum = fast_acc + bit_val[15:0];
		sinc3_shift = {1'b0, decimation_ratio_sel, 1'b0}
			+ {2'h0, decimation_ratio_sel};
		sinc3_scaled = ($signed({{4{comb3[43]}}, comb3}) <<< 2)
			>>> sinc3_shift;
		sinc1_scaled = $signed({{32{fast_sum[15]}}, fast_sum})
			<<< (5'h10 - {2'h0, decimation_ratio_sel});
	end

	// Integrators wrap modulo 2^44, which the combs undo exactly
	always_ff @(posedge clk_i) begin
		if (rst_i || filt_clear) begin
			int1 <= 44'sh0;
			int2 <= 44'sh0;
			int3 <= 44'sh0;
			dly1 <= 44'sh0;
			dly2 <= 44'sh0;
			dly3 <= 44'sh0;
			dec_cnt <= 14'h0000;
			fast_acc <= 16'sh0000;
		end else if (mod_tick) begin
			int1 <= int1 + bit_val;
			int2 <= int2 + int1;
			int3 <= int3 + int2;
			fast_acc <= dec_tick ? 16'sh0000 : fast_sum;
			dec_cnt <= dec_tick ? 14'h0000 : dec_cnt + 14'h0001;
			if (dec_tick) begin
				dly1 <= int3;
				dly2 <= comb1;
				dly3 <= comb2;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			path <= fast_first;
		end else if (dec_tick) begin
			unique case (path)
				fast_first: path <= fast_second;
				fast_second: path <= sinc3_path;
				sinc3_path: path <= sinc3_path;
			endcase
		end
	end

	// Words pass on whether settled or not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hpf.sample <= 24'sh000000;
			hpf.sample_valid <= 1'b0;
		end else begin
			hpf.sample_valid <= dec_tick;
			if (dec_tick)
				hpf.sample <= (path == sinc3_path) ? sat24(sinc3_scaled)
					: sat24(sinc1_scaled);
		end
	end

	// ------------------------------------------------------------------
	// Settling tracker
	// ------------------------------------------------------------------
	logic [16:0] settle_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || filt_clear) begin
			settle_cnt <= 17'h00000;
			settled_o <= 1'b0;
		end else if (!settled_o) begin
			if (settle_cnt == settle_target(decimation_ratio_sel)
				- 17'h00001)
				settled_o <= 1'b1;
			else
				settle_cnt <= settle_cnt + 17'h00001;
		end
	end

	// ------------------------------------------------------------------
	// DC block stage and output register
	// ------------------------------------------------------------------
	assign hpf.coeff_sel = hpf_coeff_sel;
	assign hpf.bypass = chan_hpf_disable;

	dc_block u_dc_block (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.hpf(hpf.filt)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o <= 24'sh000000;
			data_valid_o <= 1'b0;
		end else begin
			data_valid_o <= hpf.result_valid;
			if (hpf.result_valid)
				data_o <= hpf.result;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [16:0] gap_cnt;
	logic gap_armed;

	always_ff @(posedge clk_i) begin
		if (rst_i || filt_clear) begin
			gap_cnt <= 17'h00000;
			gap_armed <= 1'b0;
		end else begin
			gap_cnt <= hpf.sample_valid ? 17'h00001 : gap_cnt + 17'h00001;
			if (hpf.sample_valid)
				gap_armed <= 1'b1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_valid_pulse;
		data_valid_o |=> !data_valid_o;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse)
		else $error("valid strobe longer than one cycle");

	property p_mod_rate;
		mod_tick |=> !mod_tick ##1 mod_tick;
	endproperty
	a_mod_rate: assert property (p_mod_rate)
		else $error("modulator tick not every second clock");

	property p_word_rate;
		hpf.sample_valid && gap_armed && !filt_clear |->
			gap_cnt == {osr_len(decimation_ratio_sel), 1'b0};
	endproperty
	a_word_rate: assert property (p_word_rate)
		else $error("word spacing differs from ratio bits");

	property p_fast_step;
		dec_tick && path == fast_first |=> path == fast_second;
	endproperty
	a_fast_step: assert property (p_fast_step)
		else $error("fast path did not advance");

	property p_sinc3_stays;
		path == sinc3_path |=> path == sinc3_path;
	endproperty
	a_sinc3_stays: assert property (p_sinc3_stays)
		else $error("left sinc3 path without reset");

	property p_restart;
		restart |=> settle_cnt == 17'h00000 && !settled_o;
	endproperty
	a_restart: assert property (p_restart)
		else $error("settling not restarted");

	property p_settle_len;
		$rose(settled_o) |-> $past(settle_cnt) ==
			settle_target(decimation_ratio_sel) - 17'h00001;
	endproperty
	a_settle_len: assert property (p_settle_len)
		else $error("settling length wrong");

	property p_no_gate;
		dec_tick |-> ##3 data_valid_o;
	endproperty
	a_no_gate: assert property (p_no_gate)
		else $error("word suppressed");

	property p_ack;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack held longer than one cycle");

	c_to_sinc3: cover property (path == fast_second && dec_tick);
	c_settled: cover property ($rose(settled_o));
	c_resync: cover property (resync_rise ##1 restart);

endmodule // adc_decimation_and_dc_block

// [adc_filter_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * decimation and DC block filter. Assumes inclusion by bare name from any
 * file that needs the register map.
 */
`ifndef ADC_FILTER_REGS_SVH
`define ADC_FILTER_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLOCK_REG_ADDR 8'h00
`define HPF_REG_ADDR 8'h04
`define CHAN_CFG_ADDR 8'h08
`define STATUS_ADDR 8'h0C
`define DATA_ADDR 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CLK_OSR_LSB 0
`define CLK_PWR_LSB 8
`define HPF_SEL_LSB 0
`define CHAN_EN_BIT 0
`define CHAN_HPF_DIS_BIT 1
`define CHAN_MUX_LSB 2
`define CHAN_GAIN_LSB 4
`define STAT_SETTLED_BIT 0
`define STAT_FAST_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OSR_SEL_RST 3'h3
`define PWR_RST 2'h0
`define HPF_SEL_RST 4'h0
`define CHAN_EN_RST 1'b1
`define CHAN_HPF_DIS_RST 1'b0
`define CHAN_MUX_RST 2'h0
`define CHAN_GAIN_RST 3'h0

// ----------------------------------------------------------------------
// Timing counts, in master clock cycles
// ----------------------------------------------------------------------
`define SETTLE_OSR128 860
`define SETTLE_OSR256 1628
`define SETTLE_OSR512 3164
`define SETTLE_OSR1024 6236
`define SETTLE_OSR2048 12380
`define SETTLE_OSR4096 24668
`define SETTLE_OSR8192 49244
`define SETTLE_OSR16384 98396

`endif

// [adc_filter_pkg.sv]
/*
 * Types and shared arithmetic of the decimation and DC block filter.
 * Assumes nothing of its surroundings.
 */
package adc_filter_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		high_res_mode = 2'h0,
		low_power_mode = 2'h1,
		very_low_power_mode = 2'h2
	} power_mode_t;

	typedef enum logic [1:0] {
		fast_first = 2'h0,
		fast_second = 2'h1,
		sinc3_path = 2'h3
	} path_t;

	// ------------------------------------------------------------------
	// Saturation to a 24-bit conversion word
	// ------------------------------------------------------------------
	function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
		if (v > 48'sh0000007FFFFF)
			sat24 = 24'sh7FFFFF;
		else if (v < -48'sh000000800000)
			sat24 = 24'sh800000;
		else
			sat24 = v[23:0];
	endfunction

endpackage

// [hpf_if.sv]
/*
 * Carrier between the decimator and the DC block stage.
 * Assumes both ends share one clock.
 */
interface hpf_if;
	logic signed [23:0] sample;
	logic sample_valid;
	logic [3:0] coeff_sel;
	logic bypass;
	logic signed [23:0] result;
	logic result_valid;

	modport feed(output sample, output sample_valid, output coeff_sel,
		output bypass, input result, input result_valid);
	modport filt(input sample, input sample_valid, input coeff_sel,
		input bypass, output result, output result_valid);
endinterface

// [dc_block.sv]
/*
 * First-order recursive high-pass stage run once per decimated word.
 * Assumes sample_valid is a one-cycle strobe and controls are static.
 */
module dc_block import adc_filter_pkg::*; (
	input logic clk_i,
	input logic rst_i,
	hpf_if.filt hpf
);

	// ------------------------------------------------------------------
	// Datapath: y = x - s, s += a * y, a = 2^-(sel+1)
	// ------------------------------------------------------------------
	// Sixteen fraction bits keep the slowest pole from stalling on
	// truncation; very small steps still settle only to within an LSB.
	logic signed [39:0] acc;
	logic signed [40:0] diff;
	logic signed [40:0] step;
	logic active;

	assign active = (hpf.coeff_sel != 4'h0) && !hpf.bypass;

	always_comb begin
		diff = $signed({hpf.sample[23], hpf.sample, 16'h0000})
			- $signed({acc[39], acc});
		step = diff >>> ({1'b0, hpf.coeff_sel} + 5'h01);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !active) begin
			acc <= 40'sh0000000000;
		end else if (hpf.sample_valid) begin
			acc <= acc + step[39:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hpf.result <= 24'sh000000;
			hpf.result_valid <= 1'b0;
		end else begin
			hpf.result_valid <= hpf.sample_valid;
			if (hpf.sample_valid) begin
				if (active)
					hpf.result <= sat24(48'(diff >>> 16));
				else
					hpf.result <= hpf.sample;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_bypass;
		hpf.sample_valid && !active |=> hpf.result == $past(hpf.sample);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypassed word not passed through");

	property p_hpf_valid;
		hpf.sample_valid |=> hpf.result_valid ##1 !hpf.result_valid;
	endproperty
	a_hpf_valid: assert property (p_hpf_valid)
		else $error("high-pass stage valid timing wrong");

	property p_acc_idle;
		!active |=> acc == 40'sh0000000000;
	endproperty
	a_acc_idle: assert property (p_acc_idle)
		else $error("disabled stage kept state");

	c_hpf_active: cover property (hpf.sample_valid && active);

endmodule // dc_block

// [mod_stream_model.sv]
/*
 * Behavioural delta-sigma modulator feeding the filter's bit pin.
 * Assumes one clock shared with the filter and a density of 0 to 256.
 */
module mod_stream_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [8:0] density_i,
	output logic mod_bit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// First-order loop, one bit every second clock
	// ---------------------------------------------------------------
	logic tick;
	logic [9:0] acc;
	logic [9:0] sum;
	assign sum = acc + {1'b0, density_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick <= 1'b0;
			acc <= 10'h000;
			mod_bit_o <= 1'b0;
		end else begin
			tick <= ~tick;
			if (tick) begin
				mod_bit_o <= (sum >= 10'h100);
				acc <= (sum >= 10'h100) ? sum - 10'h100 : sum;
			end
		end
	end
endmodule // mod_stream_model

// [adc_decimation_and_dc_block_tb.sv]
/*
 * Self-checking bench of one filter channel, with a modulator model.
 * Assumes the filter package and register header are compiled first.
 */
`include "adc_filter_regs.svh"

module adc_decimation_and_dc_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FS = 8388607;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic sync = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic ack, mbit, dvalid, settled;
	logic signed [23:0] dout, w, w0, w1;
	logic [1:0] pm_o;
	logic [8:0] density = 9'h100;
	int bad_count = 0, compares = 0, n, nw, d, cfg;
	time t0, t1;

	adc_decimation_and_dc_block u_adc_decimation_and_dc_block (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .mod_bit_i(mbit), .sync_i(sync),
		.data_o(dout), .data_valid_o(dvalid), .settled_o(settled),
		.power_mode_o(pm_o));
	mod_stream_model u_mod_stream_model (.clk_i(clk_i), .rst_i(rst_i),
		.density_i(density), .mod_bit_o(mbit));

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// ---------------------------------------------------------------
	// Compare, bus and stream tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic near(input logic signed [31:0] got, input int e, tol);
		compares++;
		if ((^got === 1'bx) || got > e + tol || got < e - tol) begin
			bad_count++;
			$display("MISMATCH t=%0t got %0d exp %0d", $time, got, e);
		end
	endtask
	// Holds the request up to the edge that samples ack, releases there
	task automatic wb(input logic wr, input logic [7:0] a,
		input logic [31:0] dat, output logic [31:0] rd);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= dat;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (k >= 50) near(0, 1, 0);
	endtask
	task automatic word(output logic signed [23:0] v, output time t);
		int k;
		k = 0;
		do begin
			@(negedge clk_i);
			k++;
		end while (dvalid !== 1'b1 && k < 40000);
		if (k >= 40000) near(0, 1, 0);
		v = dout;
		t = $time;
		@(negedge clk_i);
		chk(32'(dvalid), 32'h0);
	endtask
	function automatic int model_word(input int dens);
		int v;
		v = (2 * dens - 256) * 32768;
		return (v > FS) ? FS : v;
	endfunction
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#1ms;
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		test_done();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h539a67b6));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// Second pass resets mid-run: the fast path must come back
		for (int rr = 0; rr < 2; rr++) begin
			if (rr == 1) begin
				rst_i <= 1'b1;
				repeat (2) @(posedge clk_i);
				rst_i <= 1'b0;
			end
			wb(1'b0, `STATUS_ADDR, 32'h0, r);
			chk(32'(r[1:0]), 32'h2);
			word(w, t0);
			// Reset zeros of model and synchroniser lead the first window
			near(w, FS, 65536);
			word(w, t0);
			chk(32'(w), 32'h7FFFFF);
			wb(1'b0, `STATUS_ADDR, 32'h0, r);
			chk(32'(r[1:0]), 32'h0);
		end
		$display("startup test done");
		for (int p = 0; p < 3; p++) begin
			wb(1'b1, `CLOCK_REG_ADDR, 32'(p << 8) | 32'h3, r);
			wb(1'b0, `CLOCK_REG_ADDR, 32'h0, r);
			chk(32'(r[9:0]), 32'(p << 8) | 32'h3);
			chk(32'(pm_o), 32'(p));
		end
		sel <= 4'h0;
		wb(1'b1, `CLOCK_REG_ADDR, 32'h0, r);
		sel <= 4'hF;
		wb(1'b0, `CLOCK_REG_ADDR, 32'h0, r);
		chk(32'(r[9:0]), 32'h203);
		wb(1'b0, 8'h20, 32'h0, r);
		chk(r, 32'h0);
		$display("register test done");
		for (int s = 7; s >= 0; s--) begin
			wb(1'b1, `CLOCK_REG_ADDR, 32'(s), r);
			wb(1'b0, `CLOCK_REG_ADDR, 32'h0, r);
			chk(32'(r[2:0]), 32'(s));
			if (s < 5) begin
				word(w, t0);
				word(w, t1);
				chk(32'(t1 - t0), 32'(20 * (128 << s)));
			end
		end
		$display("ratio test done");
		cfg = 1;
		// Gain change, resync pin, then channel off and on with new input
		for (int kind = 0; kind < 3; kind++) begin
			d = 32 + $urandom % 193;
			density <= 9'(d);
			if (kind == 1) begin
				@(posedge clk_i);
				sync <= 1'b1;
				repeat (3) @(posedge clk_i);
				sync <= 1'b0;
			end else begin
				if (kind == 2)
					wb(1'b1, `CHAN_CFG_ADDR, 32'(cfg & ~1), r);
				cfg = cfg + ((kind == 0) ? 16 : 4);
				wb(1'b1, `CHAN_CFG_ADDR, 32'(cfg), r);
			end
			n = 0;
			nw = 0;
			while (settled !== 1'b0 && n < 10) begin
				@(negedge clk_i);
				n++;
			end
			chk(32'(settled), 32'h0);
			do begin
				@(negedge clk_i);
				n++;
				if (dvalid === 1'b1) nw++;
			end while (settled !== 1'b1 && n < 3000);
			near(n, 860, 8);
			chk(32'(nw), 32'h3);
			word(w, t0);
			near(w, model_word(d), 262144);
		end
		$display("settling test done");
		density <= 9'h100;
		repeat (5) word(w, t0);
		for (int k = 1; k < 16; k++) begin
			word(w, t0);
			wb(1'b1, `HPF_REG_ADDR, 32'h0, r);
			word(w, t0);
			near(w, FS, 0);
			wb(1'b1, `HPF_REG_ADDR, 32'(k), r);
			word(w0, t0);
			word(w1, t0);
			near(w0, FS, 2);
			near(w1, FS - (FS >>> (k + 1)), 2);
		end
		wb(1'b1, `CHAN_CFG_ADDR, 32'(cfg | 2), r);
		repeat (3) word(w, t0);
		near(w, FS, 0);
		wb(1'b1, `HPF_REG_ADDR, 32'h1, r);
		wb(1'b1, `CHAN_CFG_ADDR, 32'(cfg), r);
		repeat (40) word(w, t0);
		near(w, 0, 200);
		$display("dc block test done");
		test_done();
	end
endmodule // adc_decimation_and_dc_block_tb
